// [sss_pkg.sv]
// package of constants for the slave-select / output-enable block
// assumes nothing beyond a SystemVerilog compiler
package sss_pkg;
  localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TMR = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSS = 4'h5;
  localparam int BITS_PER_FRAME = 8;
  localparam int CNT_W = 3;
  localparam int DIV_W = 6;
  localparam logic [7:0] RESET_DIR = 8'hff;
  localparam int SDO_DIR_BIT = 5;
  localparam logic [7:0] RESET_DATA = 8'h00;
endpackage

// [sss_sync.sv]
// two-flop synchroniser for one level from outside the clock domain
// assumes clock and arst_n of the core domain
`timescale 1ns/1ps
module sss_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic sync_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule

// [sss_core.sv]
////////////////////////////////////////////////////////////////////////////
// synchronous serial port core: shift logic, port c direction, pin muxing
// assumes pins are asynchronous to clock; cpu side ports are synchronous
`timescale 1ns/1ps
module sss_core (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] sync_serial_control,
  input wire logic port_enable,
  input wire logic clock_edge_sel,
  input wire logic clock_idle_high,
  input wire logic [7:0] tx_data,
  input wire logic tx_load,
  output logic [7:0] rx_data,
  output logic rx_done,
  input wire logic [7:0] dir_wr_data,
  input wire logic dir_wr,
  input wire logic dir_rmw,
  output logic [7:0] port_c_direction_reg,
  input wire logic port_a_bit_five_in,
  input wire logic port_c_bit_three_in,
  output logic port_c_bit_three_out,
  output logic port_c_bit_three_oe,
  input wire logic port_c_bit_four_in,
  output logic port_c_bit_five_out,
  output logic port_c_bit_five_oe,
  output logic ss_mode_err
);
  ////////////////////////////////////////////////////////////////////////
  logic ss_sync;
  logic sck_sync;
  logic sdi_sync;
  // select resets to its idle level so sdo is not enabled just after reset
  sss_sync #(.RST_VAL(1'b1)) u_ss (.clock(clock), .arst_n(arst_n),
    .d(port_a_bit_five_in), .q(ss_sync));
  sss_sync u_sck (.clock(clock), .arst_n(arst_n), .d(port_c_bit_three_in),
    .q(sck_sync));
  sss_sync u_sdi (.clock(clock), .arst_n(arst_n), .d(port_c_bit_four_in),
    .q(sdi_sync));

  logic is_master;
  logic is_slave;
  logic ss_ctrl;
  logic shift_reset;
  logic periph_oe;
  assign is_master = port_enable && (sync_serial_control[3:2] == 2'b00);
  assign is_slave = port_enable &&
    (sync_serial_control == sss_pkg::MODE_SLAVE_SS ||
     sync_serial_control == sss_pkg::MODE_SLAVE_NOSS);
  assign ss_ctrl = port_enable &&
    (sync_serial_control == sss_pkg::MODE_SLAVE_SS);
  assign shift_reset = !port_enable || (ss_ctrl && ss_sync);
  // output enable drops while the master deselects us
  assign periph_oe = port_enable && !(ss_ctrl && ss_sync);
  // flags the illegal combination; hardware still obeys the mode field
  assign ss_mode_err = is_slave && !ss_ctrl && clock_edge_sel;

  ////////////////////////////////////////////////////////////////////////
  // master clock divider, and edge detection on the sampled clock
  logic [sss_pkg::DIV_W-1:0] div_ff, nxt_div;
  logic sck_prev_ff, nxt_sck_prev;
  logic msck_ff, nxt_msck;
  logic [sss_pkg::DIV_W-1:0] div_top;
  logic tick;
  always_comb begin
    unique case (sync_serial_control[1:0])
      2'b00: div_top = 6'h01;
      2'b01: div_top = 6'h07;
      default: div_top = 6'h1f;
    endcase
    tick = is_master && (div_ff == div_top);
    nxt_div = (!is_master || tick) ? '0 : div_ff + 6'h01;
    nxt_sck_prev = sck_sync;
  end

  typedef enum logic [1:0] {SSS_IDLE = 2'b00, SSS_RUN = 2'b01} sss_state_t;
  sss_state_t st_ff, nxt_st;
  logic [7:0] sr_ff, nxt_sr;
  logic [sss_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [7:0] rx_ff, nxt_rx;
  logic done_ff, nxt_done;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic shift_edge;
  logic sck_rise;
  logic sck_fall;
  logic busy;
  logic sdo_ff, nxt_sdo;
  always_comb begin
    sck_rise = is_master ? (tick && !msck_ff) : (sck_sync && !sck_prev_ff);
    sck_fall = is_master ? (tick && msck_ff) : (!sck_sync && sck_prev_ff);
    lead_edge = clock_idle_high ? sck_fall : sck_rise;
    trail_edge = clock_idle_high ? sck_rise : sck_fall;
    // edge select 1: data changes on the edge to idle, sampled on leading
    sample_edge = clock_edge_sel ? lead_edge : trail_edge;
    shift_edge = clock_edge_sel ? trail_edge : lead_edge;
    // idle slave takes the first edge too: the frame starts at the pin
    unique case (st_ff)
      SSS_IDLE: busy = is_slave;
      SSS_RUN: busy = 1'b1;
      default: busy = 1'b0;
    endcase
    nxt_st = (st_ff == SSS_RUN) ? SSS_RUN : SSS_IDLE;
    nxt_sr = sr_ff;
    nxt_cnt = cnt_ff;
    nxt_rx = rx_ff;
    nxt_done = 1'b0;
    nxt_sdo = sdo_ff;
    nxt_msck = clock_idle_high;
    if (shift_reset) begin
      nxt_st = SSS_IDLE;
      nxt_cnt = '0;
    end else if (tx_load) begin
      nxt_sr = tx_data;
      nxt_cnt = '0;
      nxt_st = SSS_RUN;
      // first bit stands on the pin before any clock edge
      nxt_sdo = tx_data[7];
    end else begin
      if (is_master && st_ff == SSS_RUN) begin
        nxt_msck = tick ? !msck_ff : msck_ff;
      end
      // sample and shift share one register: the sampled bit enters at
      // the bottom while the bit on the pin is taken from the top
      if (busy && shift_edge) begin
        nxt_sdo = sr_ff[7];
      end
      if (busy && sample_edge) begin
        nxt_sr = {sr_ff[6:0], sdi_sync};
        nxt_cnt = cnt_ff + 3'h1;
        nxt_st = SSS_RUN;
        if (cnt_ff == 3'h7) begin
          nxt_rx = {sr_ff[6:0], sdi_sync};
          nxt_done = 1'b1;
          nxt_st = SSS_IDLE;
        end
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= '0;
      sck_prev_ff <= 1'b0;
      msck_ff <= 1'b0;
      st_ff <= SSS_IDLE;
      sr_ff <= sss_pkg::RESET_DATA;
      cnt_ff <= '0;
      rx_ff <= sss_pkg::RESET_DATA;
      done_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      sck_prev_ff <= nxt_sck_prev;
      msck_ff <= nxt_msck;
      st_ff <= nxt_st;
      sr_ff <= nxt_sr;
      cnt_ff <= nxt_cnt;
      rx_ff <= nxt_rx;
      done_ff <= nxt_done;
      sdo_ff <= nxt_sdo;
    end
  end
  assign rx_data = rx_ff;
  assign rx_done = done_ff;

  ////////////////////////////////////////////////////////////////////////
  // direction register; in slave-select mode bit five reads through the peripheral enable
  logic [7:0] dir_ff, nxt_dir;
  logic [7:0] dir_view;
  always_comb begin
    dir_view = dir_ff;
    if (ss_ctrl) begin
      dir_view[sss_pkg::SDO_DIR_BIT] = dir_ff[sss_pkg::SDO_DIR_BIT] ||
        !periph_oe;
    end
    nxt_dir = dir_ff;
    if (dir_wr) begin
      nxt_dir = dir_wr_data;
    end else if (dir_rmw) begin
      // the cpu writes back what it read, so a high select sets the bit
      nxt_dir = dir_wr_data | (dir_view & ~dir_ff);
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dir_ff <= sss_pkg::RESET_DIR;
    end else begin
      dir_ff <= nxt_dir;
    end
  end
  assign port_c_direction_reg = dir_view;

  ////////////////////////////////////////////////////////////////////////
  assign port_c_bit_five_out = sdo_ff;
  assign port_c_bit_five_oe = periph_oe &&
    !dir_view[sss_pkg::SDO_DIR_BIT];
  assign port_c_bit_three_out = msck_ff;
  assign port_c_bit_three_oe = is_master &&
    !dir_ff[sss_pkg::SDO_DIR_BIT - 2];

  ////////////////////////////////////////////////////////////////////////
  AST_SS_RESET: assert property (@(posedge clock) disable iff (!arst_n)
    shift_reset |=> st_ff == SSS_IDLE && cnt_ff == '0)
    else $error("shift logic not reset by select");
  AST_DIR_VIEW: assert property (@(posedge clock) disable iff (!arst_n)
    (ss_ctrl && ss_sync) |-> port_c_direction_reg[5])
    else $error("sdo direction not forced while deselected");
  AST_RMW_SET: assert property (@(posedge clock) disable iff (!arst_n)
    (dir_rmw && !dir_wr && ss_ctrl && ss_sync) |=> dir_ff[5])
    else $error("rmw did not set sdo direction");
  AST_OE_GATE: assert property (@(posedge clock) disable iff (!arst_n)
    port_c_bit_five_oe |-> !port_c_direction_reg[5] && periph_oe)
    else $error("sdo driven without enable");
  AST_SCK_DIR: assert property (@(posedge clock) disable iff (!arst_n)
    is_slave |-> !port_c_bit_three_oe)
    else $error("slave drives clock pin");
  AST_MODE_ERR: assert property (@(posedge clock) disable iff (!arst_n)
    (is_slave && clock_edge_sel && !ss_ctrl) |-> ss_mode_err)
    else $error("illegal edge mode not flagged");
  AST_SS_PIN: assert property (@(posedge clock) disable iff (!arst_n)
    (ss_ctrl && $past(port_a_bit_five_in, 2) && $past(ss_ctrl, 2)
     && $past(port_a_bit_five_in, 1)) |-> !periph_oe)
    else $error("select pin not honoured");
  AST_DONE_PULSE: assert property (@(posedge clock) disable iff (!arst_n)
    rx_done |=> !rx_done)
    else $error("done held over one cycle");
  COV_SLAVE_BYTE: cover property (@(posedge clock) disable iff (!arst_n)
    is_slave && rx_done);
  COV_DESELECT: cover property (@(posedge clock) disable iff (!arst_n)
    ss_ctrl && st_ff == SSS_RUN ##1 shift_reset);
  COV_RMW: cover property (@(posedge clock) disable iff (!arst_n)
    dir_rmw && ss_ctrl && ss_sync);
  COV_MASTER: cover property (@(posedge clock) disable iff (!arst_n)
    is_master && rx_done);
endmodule

// [sss_spi_master_model.sv]
// spi master model that drives the clock, select and data pins of the core
// assumes an idle-low clock and sampling on the trailing edge
`timescale 1ns/1ps
module sss_spi_master_model (
  input wire logic miso,
  output logic sck,
  output logic ss_n,
  output logic mosi
);
  logic [7:0] got;
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    got = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // msb first; data changes on the leading edge and is held through the
  // trailing one, where both sides sample; 320 ns clock period
  task automatic shift(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      #160 sck = 1'b1;
      mosi = d[7-i];
      #160 got = {got[6:0], miso};
      sck = 1'b0;
    end
    // half a period of hold so the slave still sees the last bit
    #160 mosi = ~mosi;
  endtask
  // released data line shows the inverse of its last value, not a held bit
  task automatic select(input logic act);
    #53 ss_n = !act;
    mosi = ~mosi;
  endtask
endmodule

// [tb_sss_core.sv]
// self-checking bench for the slave-select and output-enable core
// assumes the master model file is compiled first
`timescale 1ns/1ps
module tb_sss_core;
  logic clock, arst_n, port_enable, clock_edge_sel, tx_load, dir_wr, dir_rmw;
  logic [3:0] sync_serial_control;
  logic [7:0] tx_data, dir_wr_data, rx_data, port_c_direction_reg;
  logic rx_done, c3_out, c3_oe, c5_out, c5_oe, ss_mode_err, sck, ss_n, mosi;
  logic clock_idle_high, c3_last;
  int toggles = 0;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  sss_core i_sss_core (.clock(clock), .arst_n(arst_n),
    .sync_serial_control(sync_serial_control), .port_enable(port_enable),
    .clock_edge_sel(clock_edge_sel), .clock_idle_high(clock_idle_high),
    .tx_data(tx_data), .tx_load(tx_load), .rx_data(rx_data),
    .rx_done(rx_done), .dir_wr_data(dir_wr_data), .dir_wr(dir_wr),
    .dir_rmw(dir_rmw), .port_c_direction_reg(port_c_direction_reg),
    .port_a_bit_five_in(ss_n), .port_c_bit_three_in(sck),
    .port_c_bit_three_out(c3_out), .port_c_bit_three_oe(c3_oe),
    .port_c_bit_four_in(mosi), .port_c_bit_five_out(c5_out),
    .port_c_bit_five_oe(c5_oe), .ss_mode_err(ss_mode_err));
  sss_spi_master_model i_sss_spi_master_model (.miso(c5_out), .sck(sck),
    .ss_n(ss_n), .mosi(mosi));
  // counts clock pin changes; the count trails the pin by one edge
  always @(posedge clock) begin
    c3_last <= c3_out;
    if (c3_out !== c3_last) begin
      toggles++;
    end
  end
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // the whole run needs about 250 cycles; the ceiling leaves wide margin
  always @(posedge clock) begin
    cycles++;
    if (cycles > 5000) begin
      failures++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic dir_op(input logic [7:0] v, input logic rmw);
    @(posedge clock);
    dir_wr_data <= v;
    dir_wr <= !rmw;
    dir_rmw <= rmw;
    @(posedge clock);
    dir_wr <= 1'b0;
    dir_rmw <= 1'b0;
    repeat (2) @(negedge clock);
  endtask
  // pins pass two flops, so four cycles is ample settling
  task automatic settle();
    repeat (4) @(negedge clock);
  endtask
  task automatic load(input logic [7:0] v);
    @(posedge clock);
    tx_data <= v;
    tx_load <= 1'b1;
    @(posedge clock);
    tx_load <= 1'b0;
  endtask
  task automatic wait_done(input logic [7:0] e);
    int k;
    k = 0;
    @(negedge clock);
    while (rx_done !== 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
    chk("rx_done", 8'h01, {7'h00, rx_done});
    chk("rx_data", e, rx_data);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    port_enable = 1'b1;
    clock_edge_sel = 1'b0;
    clock_idle_high = 1'b0;
    tx_load = 1'b0;
    dir_wr = 1'b0;
    dir_rmw = 1'b0;
    tx_data = 8'h00;
    dir_wr_data = 8'h00;
    sync_serial_control = sss_pkg::MODE_SLAVE_SS;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk("dir reset", sss_pkg::RESET_DIR, port_c_direction_reg);
    chk("sdo oe reset", 8'h00, {7'h00, c5_oe});
    $display("test reset done");
    dir_op(8'h00, 1'b0);
    chk("dir deselected", 8'h20, port_c_direction_reg);
    chk("sdo oe deselected", 8'h00, {7'h00, c5_oe});
    i_sss_spi_master_model.select(1'b1);
    settle();
    chk("dir selected", 8'h00, port_c_direction_reg);
    chk("sdo oe selected", 8'h01, {7'h00, c5_oe});
    chk("sck oe slave", 8'h00, {7'h00, c3_oe});
    load(8'h5a);
    fork
      i_sss_spi_master_model.shift(8'ha5, 8);
      wait_done(8'ha5);
    join
    chk("sdo byte", 8'h5a, i_sss_spi_master_model.got);
    $display("test slave byte done");
    i_sss_spi_master_model.shift(8'hff, 3);
    i_sss_spi_master_model.select(1'b0);
    settle();
    i_sss_spi_master_model.select(1'b1);
    settle();
    fork
      i_sss_spi_master_model.shift(8'h3c, 8);
      wait_done(8'h3c);
    join
    $display("test deselect reset done");
    i_sss_spi_master_model.select(1'b0);
    settle();
    // cpu sets bit 0 on the readback 8'h20, so bit 5 comes back set
    dir_op(8'h21, 1'b1);
    i_sss_spi_master_model.select(1'b1);
    settle();
    chk("dir after rmw", 8'h21, port_c_direction_reg);
    chk("sdo oe after rmw", 8'h00, {7'h00, c5_oe});
    $display("test rmw done");
    @(posedge clock);
    sync_serial_control <= sss_pkg::MODE_SLAVE_NOSS;
    clock_edge_sel <= 1'b1;
    @(negedge clock);
    chk("mode error", 8'h01, {7'h00, ss_mode_err});
    @(posedge clock);
    clock_edge_sel <= 1'b0;
    @(negedge clock);
    chk("mode ok", 8'h00, {7'h00, ss_mode_err});
    @(posedge clock);
    sync_serial_control <= sss_pkg::MODE_MASTER_DIV4;
    clock_idle_high <= 1'b1;
    dir_op(8'h00, 1'b0);
    chk("sck oe master", 8'h01, {7'h00, c3_oe});
    chk("sck idle high", 8'h01, {7'h00, c3_out});
    // the data pin stands still, so every sampled bit equals its level
    toggles = 0;
    load(8'hc3);
    wait_done({8{mosi}});
    settle();
    chk("sck edges", 8'h10, toggles[7:0]);
    @(posedge clock);
    port_enable <= 1'b0;
    @(negedge clock);
    chk("sck oe off", 8'h00, {7'h00, c3_oe});
    $display("test modes done");
    report_and_stop();
  end
endmodule
